/* hw/hpgc_pkg.sv */
// Package with register map, field layout, timing and types for the headphone gain control block
`default_nettype none
package hpgc_pkg;
  // Register offsets
  localparam logic [7:0] MIX_GAIN_ADDR = 8'h2b;
  localparam logic [7:0] LEFT_VOL_ADDR = 8'h2c;
  localparam logic [7:0] RIGHT_VOL_ADDR = 8'h2d;
  localparam logic [7:0] ZC_CFG_ADDR = 8'h40;
  // Field positions
  localparam int LEFT_ATTEN_LSB = 0;
  localparam int RIGHT_ATTEN_LSB = 2;
  localparam int LEFT_SRC_BIT = 4;
  localparam int RIGHT_SRC_BIT = 5;
  localparam int SILENCE_BIT = 7;
  localparam int SMOOTH_OFF_BIT = 0;
  localparam int CROSSING_GATE_BIT = 2;
  // Reset values and top volume code
  localparam logic [4:0] LEVEL_CODE_RST = 5'h1a;
  localparam logic [4:0] LEVEL_CODE_MAX = 5'h1f;
  localparam logic [1:0] ATTEN_RST = 2'h0;
  // Range thresholds in percent of supply
  localparam logic [6:0] RANGE2_PCT = 7'h0a;
  localparam logic [6:0] RANGE3_PCT = 7'h19;
  // Nominal switching rates in kHz
  localparam logic [9:0] RANGE1_KHZ = 10'h052;
  localparam logic [9:0] RANGE2_KHZ = 10'h294;
  localparam logic [9:0] RANGE3_KHZ = 10'h1f4;
  // Timing
  localparam int CLK_HZ = 50000000;
  localparam int DOWN_DELAY_MS = 32;
  localparam int ZC_TIMEOUT_MS = 100;
  localparam int SMOOTH_STEP_MS = 1;
  localparam int DOWN_DELAY_CYC = CLK_HZ / 1000 * DOWN_DELAY_MS;
  localparam int ZC_TIMEOUT_CYC = CLK_HZ / 1000 * ZC_TIMEOUT_MS;
  localparam int SMOOTH_STEP_CYC = CLK_HZ / 1000 * SMOOTH_STEP_MS;

  typedef enum logic [1:0] {HPGC_RANGE_LOW, HPGC_RANGE_MID, HPGC_RANGE_HIGH} hpgc_range_t;

  // Register access request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } hpgc_reg_req_t;

  // Per-channel headphone path control
  typedef struct packed {
    logic signed [8:0] gain_hdb;
    logic [4:0] level_code;
    logic silenced;
    logic src_mixer;
    logic [1:0] mix_atten;
  } hpgc_chan_t;

  // Volume code to gain in half-dB steps
  function automatic logic signed [8:0] hpgc_gain_hdb(input logic [4:0] code);
    logic signed [8:0] g;
    g = 9'sh000;
    case (code)
      5'h00: g = -9'sd134;
      5'h01: g = -9'sd126;
      5'h02: g = -9'sd118;
      5'h03: g = -9'sd110;
      5'h04: g = -9'sd102;
      5'h05: g = -9'sd94;
      5'h06: g = -9'sd86;
      5'h07: g = -9'sd80;
      5'h08: g = -9'sd74;
      5'h09: g = -9'sd68;
      5'h0a: g = -9'sd62;
      5'h0b: g = -9'sd56;
      5'h0c: g = -9'sd50;
      5'h0d: g = -9'sd44;
      5'h0e: g = -9'sd38;
      5'h0f: g = -9'sd34;
      5'h10: g = -9'sd30;
      5'h11: g = -9'sd26;
      5'h12: g = -9'sd22;
      5'h13: g = -9'sd18;
      5'h14: g = -9'sd14;
      5'h15: g = -9'sd10;
      5'h16: g = -9'sd8;
      5'h17: g = -9'sd6;
      5'h18: g = -9'sd4;
      5'h19: g = -9'sd2;
      5'h1a: g = 9'sd0;
      5'h1b: g = 9'sd2;
      5'h1c: g = 9'sd3;
      5'h1d: g = 9'sd4;
      5'h1e: g = 9'sd5;
      default: g = 9'sd6;
    endcase
    return g;
  endfunction
endpackage
`default_nettype wire

/* hw/hpgc_ctrl.sv */
// Headphone gain, routing, zero-crossing volume update and charge-pump range control
`default_nettype none
//
// Contract
// - Two-bit mixer attenuation per channel, right above left
// - Source bit: zero direct converter, one mixer
// - Five-bit volume code through fixed gain lookup
// - Bit 7 mute silences channel, else volume follows
// - Reset volume 11010, mute clear
// - Three supply ranges at 10 and 25 percent
// - Ranges 1-2 half rails, range 3 full
// - Rates about 82, 660, 500 kHz
// - Upward range change happens at once
// - Downward change waits 32 ms after detection
// - Gated volume change applies at signal midpoint
// - No crossing in 100 ms applies change anyway
// - Gate bit zero gates, one applies immediately
// - Smoothing ramps one code step per 1 ms
module hpgc_ctrl #(
  parameter int DOWN_DELAY = hpgc_pkg::DOWN_DELAY_CYC,
  parameter int ZC_TIMEOUT = hpgc_pkg::ZC_TIMEOUT_CYC,
  parameter int STEP_TIME = hpgc_pkg::SMOOTH_STEP_CYC
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // Register port
  input wire hpgc_pkg::hpgc_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  // Audio path observations
  input wire logic [1:0] zero_cross_in,
  input wire logic [6:0] left_level_pct_in,
  input wire logic [6:0] right_level_pct_in,
  // Headphone channel controls, index 0 left, 1 right
  output hpgc_pkg::hpgc_chan_t chan_out [2],
  // Charge pump controls
  output hpgc_pkg::hpgc_range_t cp_range_out,
  output logic cp_full_rail_out,
  output logic [9:0] cp_rate_khz_out
);
  // Each counter needs at least one cycle; zero would underflow the last-count constants
  if (DOWN_DELAY < 1) begin : g_bad_down_delay
    $error("hpgc_ctrl: DOWN_DELAY must be at least one");
  end
  if (ZC_TIMEOUT < 1) begin : g_bad_zc_timeout
    $error("hpgc_ctrl: ZC_TIMEOUT must be at least one");
  end
  if (STEP_TIME < 1) begin : g_bad_step_time
    $error("hpgc_ctrl: STEP_TIME must be at least one");
  end

  localparam int DW = $clog2(DOWN_DELAY + 1);
  localparam int ZW = $clog2(ZC_TIMEOUT + 1);
  localparam int SW = $clog2(STEP_TIME + 1);
  localparam logic [DW-1:0] DOWN_LAST = DW'(DOWN_DELAY - 1);
  localparam logic [ZW-1:0] ZC_LAST = ZW'(ZC_TIMEOUT - 1);
  localparam logic [SW-1:0] STEP_LAST = SW'(STEP_TIME - 1);

  // Register storage
  logic [1:0] atten_reg [2];
  logic [1:0] src_reg;
  logic [1:0] silence_reg;
  logic [4:0] target_reg [2];
  logic crossing_gate_ctrl_reg;
  logic smooth_off_reg;

  // Address decode
  wire logic wr_mix = reg_req_in.wr && reg_req_in.addr == hpgc_pkg::MIX_GAIN_ADDR;
  wire logic wr_zc = reg_req_in.wr && reg_req_in.addr == hpgc_pkg::ZC_CFG_ADDR;
  wire logic [1:0] wr_vol = {reg_req_in.wr && reg_req_in.addr == hpgc_pkg::RIGHT_VOL_ADDR,
                             reg_req_in.wr && reg_req_in.addr == hpgc_pkg::LEFT_VOL_ADDR};
  wire logic [7:0] wd = reg_req_in.wdata;

  // Shared configuration registers
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      atten_reg[0] <= hpgc_pkg::ATTEN_RST;
      atten_reg[1] <= hpgc_pkg::ATTEN_RST;
      src_reg <= 2'h0;
      crossing_gate_ctrl_reg <= 1'b0;
      smooth_off_reg <= 1'b0;
    end else begin
      if (wr_mix) begin
        atten_reg[0] <= wd[hpgc_pkg::LEFT_ATTEN_LSB +: 2];
        atten_reg[1] <= wd[hpgc_pkg::RIGHT_ATTEN_LSB +: 2];
        src_reg <= {wd[hpgc_pkg::RIGHT_SRC_BIT], wd[hpgc_pkg::LEFT_SRC_BIT]};
      end
      if (wr_zc) begin
        crossing_gate_ctrl_reg <= wd[hpgc_pkg::CROSSING_GATE_BIT];
        smooth_off_reg <= wd[hpgc_pkg::SMOOTH_OFF_BIT];
      end
    end
  end

  // Per-channel volume, mute and gated update
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [4:0] applied_reg;
    logic [ZW-1:0] zc_cnt_reg;
    logic [SW-1:0] pace_cnt_reg;
    logic pace_ok_reg;
    wire logic pending = applied_reg != target_reg[ch];
    wire logic timed_out = zc_cnt_reg == ZC_LAST;
    wire logic gate_open = crossing_gate_ctrl_reg || zero_cross_in[ch] || timed_out;
    wire logic smoothing = !smooth_off_reg;
    // Ready on the cycle the count completes, so one step takes exactly STEP_TIME cycles
    wire logic pace_ready = pace_ok_reg || pace_cnt_reg == STEP_LAST;
    wire logic do_apply = pending && gate_open && (!smoothing || pace_ready);
    wire logic [4:0] step_code = (target_reg[ch] > applied_reg) ? applied_reg + 5'h01 : applied_reg - 5'h01;
    wire logic [4:0] next_code = smoothing ? step_code : target_reg[ch];

    always_ff @(posedge clock_in) begin
      if (srst_in) begin
        target_reg[ch] <= hpgc_pkg::LEVEL_CODE_RST;
        silence_reg[ch] <= 1'b0;
      end else if (wr_vol[ch]) begin
        target_reg[ch] <= wd[4:0];
        silence_reg[ch] <= wd[hpgc_pkg::SILENCE_BIT];
      end
    end

    // Applied code moves only when the gate opens
    always_ff @(posedge clock_in) begin
      if (srst_in) begin
        applied_reg <= hpgc_pkg::LEVEL_CODE_RST;
        zc_cnt_reg <= '0;
      end else begin
        applied_reg <= do_apply ? next_code : applied_reg;
        zc_cnt_reg <= (!pending || do_apply) ? '0 : (timed_out ? zc_cnt_reg : zc_cnt_reg + 1'b1);
      end
    end

    // Step pacing for smoothing
    always_ff @(posedge clock_in) begin
      if (srst_in || do_apply) begin
        pace_cnt_reg <= '0;
        pace_ok_reg <= 1'b0;
      end else begin
        pace_cnt_reg <= pace_ok_reg ? pace_cnt_reg : pace_cnt_reg + 1'b1;
        pace_ok_reg <= pace_ok_reg || pace_cnt_reg == STEP_LAST;
      end
    end

    // Channel outputs from flip-flops
    always_ff @(posedge clock_in) begin
      if (srst_in) begin
        chan_out[ch] <= '0;
      end else begin
        chan_out[ch].level_code <= applied_reg;
        chan_out[ch].gain_hdb <= hpgc_pkg::hpgc_gain_hdb(applied_reg);
        chan_out[ch].silenced <= silence_reg[ch];
        chan_out[ch].src_mixer <= src_reg[ch];
        chan_out[ch].mix_atten <= atten_reg[ch];
      end
    end
  end

  // Register readback
  wire logic [7:0] rd_mix = {2'h0, src_reg[1], src_reg[0], atten_reg[1], atten_reg[0]};
  wire logic [7:0] rd_left = {silence_reg[0], 2'h0, target_reg[0]};
  wire logic [7:0] rd_right = {silence_reg[1], 2'h0, target_reg[1]};
  wire logic [7:0] rd_zc = {5'h00, crossing_gate_ctrl_reg, 1'b0, smooth_off_reg};
  wire logic [7:0] rd_sel = (reg_req_in.addr == hpgc_pkg::MIX_GAIN_ADDR) ? rd_mix :
                            (reg_req_in.addr == hpgc_pkg::LEFT_VOL_ADDR) ? rd_left :
                            (reg_req_in.addr == hpgc_pkg::RIGHT_VOL_ADDR) ? rd_right :
                            (reg_req_in.addr == hpgc_pkg::ZC_CFG_ADDR) ? rd_zc : 8'h00;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= rd_sel;
    end
  end

  // Charge-pump range decision from the louder channel
  wire logic [6:0] peak = (left_level_pct_in > right_level_pct_in) ? left_level_pct_in : right_level_pct_in;
  hpgc_pkg::hpgc_range_t want_range;
  assign want_range = (peak < hpgc_pkg::RANGE2_PCT) ? hpgc_pkg::HPGC_RANGE_LOW :
                      (peak < hpgc_pkg::RANGE3_PCT) ? hpgc_pkg::HPGC_RANGE_MID :
                      hpgc_pkg::HPGC_RANGE_HIGH;
  hpgc_pkg::hpgc_range_t range_reg;
  logic [DW-1:0] down_cnt_reg;
  wire logic going_up = want_range > range_reg;
  wire logic going_down = want_range < range_reg;
  wire logic down_done = down_cnt_reg == DOWN_LAST;

  // Up at once, down after the hold delay
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      range_reg <= hpgc_pkg::HPGC_RANGE_LOW;
      down_cnt_reg <= '0;
    end else if (going_up) begin
      range_reg <= want_range;
      down_cnt_reg <= '0;
    end else if (going_down) begin
      range_reg <= down_done ? want_range : range_reg;
      down_cnt_reg <= down_done ? '0 : down_cnt_reg + 1'b1;
    end else begin
      down_cnt_reg <= '0;
    end
  end

  // Rail format and switching rate per range
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cp_range_out <= hpgc_pkg::HPGC_RANGE_LOW;
      cp_full_rail_out <= 1'b0;
      cp_rate_khz_out <= hpgc_pkg::RANGE1_KHZ;
    end else begin
      cp_range_out <= range_reg;
      cp_full_rail_out <= range_reg == hpgc_pkg::HPGC_RANGE_HIGH;
      case (range_reg)
        hpgc_pkg::HPGC_RANGE_LOW: cp_rate_khz_out <= hpgc_pkg::RANGE1_KHZ;
        hpgc_pkg::HPGC_RANGE_MID: cp_rate_khz_out <= hpgc_pkg::RANGE2_KHZ;
        default: cp_rate_khz_out <= hpgc_pkg::RANGE3_KHZ;
      endcase
    end
  end
endmodule
`default_nettype wire

/* verif/hpgc_checker.sv */
// Assertion checker for the headphone gain and supply range control block
`default_nettype none
module hpgc_checker #(parameter int DOWN_DELAY = 8, parameter int ZC_TIMEOUT = 10, parameter int STEP_TIME = 4) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // Register port
  input wire hpgc_pkg::hpgc_reg_req_t reg_req_in,
  input wire logic [7:0] reg_rdata_out,
  // Audio observations
  input wire logic [1:0] zero_cross_in,
  input wire logic [6:0] left_level_pct_in,
  input wire logic [6:0] right_level_pct_in,
  // Channel and charge pump controls
  input wire hpgc_pkg::hpgc_chan_t chan_out [2],
  input wire hpgc_pkg::hpgc_range_t cp_range_out,
  input wire logic cp_full_rail_out,
  input wire logic [9:0] cp_rate_khz_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] peak;
  logic rst_d;
  logic [15:0] low_cnt;
  logic mix_wr;
  // Louder channel and write decode
  assign peak = (left_level_pct_in > right_level_pct_in) ? left_level_pct_in : right_level_pct_in;
  assign mix_wr = reg_req_in.wr && reg_req_in.addr == hpgc_pkg::MIX_GAIN_ADDR;
  // Counts consecutive cycles below the full-rail threshold
  always_ff @(posedge clock_in) begin
    rst_d <= srst_in;
    low_cnt <= (srst_in || peak >= hpgc_pkg::RANGE3_PCT) ? 16'h0000 : low_cnt + 16'h0001;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in || rst_d);
  AST_RAIL: assert property (cp_full_rail_out == (cp_range_out == hpgc_pkg::HPGC_RANGE_HIGH))
    else $error("rail flag disagrees with range");
  AST_RATE: assert property (cp_rate_khz_out == (cp_range_out == hpgc_pkg::HPGC_RANGE_LOW ? 10'h052 :
    cp_range_out == hpgc_pkg::HPGC_RANGE_MID ? 10'h294 : 10'h1f4)) else $error("rate disagrees with range");
  AST_UP: assert property (peak >= hpgc_pkg::RANGE3_PCT |-> ##2 cp_full_rail_out)
    else $error("full rail late");
  AST_DOWN_MIN: assert property ($fell(cp_full_rail_out) |-> low_cnt >= 16'(DOWN_DELAY))
    else $error("range dropped early");
  AST_DOWN_MAX: assert property (low_cnt >= 16'(DOWN_DELAY + 4) |-> !cp_full_rail_out)
    else $error("range drop missing");
  AST_GAIN: assert property ((chan_out[0].level_code != 5'h1a || chan_out[0].gain_hdb == 9'sh000) &&
    (chan_out[0].level_code != 5'h1f || chan_out[0].gain_hdb == 9'sh006)) else $error("gain lookup wrong");
  AST_RD_MUTE: assert property (reg_req_in.addr == hpgc_pkg::LEFT_VOL_ADDR |=> reg_rdata_out[7:5] ==
    {chan_out[0].silenced, 2'h0}) else $error("mute readback disagrees with output");
  AST_MUTE: assert property (reg_req_in.wr && reg_req_in.addr == hpgc_pkg::LEFT_VOL_ADDR |->
    ##2 chan_out[0].silenced == $past(reg_req_in.wdata[7], 2)) else $error("mute not applied");
  AST_ATTEN: assert property (mix_wr |-> ##2 {chan_out[1].mix_atten, chan_out[0].mix_atten} ==
    $past(reg_req_in.wdata[3:0], 2)) else $error("attenuation not applied");
  AST_SRC: assert property (mix_wr |-> ##2 {chan_out[1].src_mixer, chan_out[0].src_mixer} ==
    $past(reg_req_in.wdata[5:4], 2)) else $error("source select not applied");
  // Main scenarios
  cover property (cp_range_out == hpgc_pkg::HPGC_RANGE_HIGH ##1 cp_range_out == hpgc_pkg::HPGC_RANGE_MID);
  cover property (chan_out[0].silenced);
  cover property ($changed(chan_out[0].level_code));
  cover property (zero_cross_in[0] ##2 $changed(chan_out[0].level_code));
endmodule
bind hpgc_ctrl hpgc_checker #(.DOWN_DELAY(DOWN_DELAY), .ZC_TIMEOUT(ZC_TIMEOUT), .STEP_TIME(STEP_TIME)) u_hpgc_checker (
  .clock_in(clock_in), .srst_in(srst_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
  .zero_cross_in(zero_cross_in), .left_level_pct_in(left_level_pct_in), .right_level_pct_in(right_level_pct_in),
  .chan_out(chan_out), .cp_range_out(cp_range_out), .cp_full_rail_out(cp_full_rail_out),
  .cp_rate_khz_out(cp_rate_khz_out));
`default_nettype wire

/* verif/hpgc_load.sv */
// Headphone load model reporting output level and midpoint crossings
`default_nettype none
module hpgc_load (
  // Clock and commanded swing
  input wire logic clock_in,
  input wire logic [6:0] amp_in,
  input wire logic zc_en_in,
  // Observations for the control block
  output logic [1:0] zero_cross_out = 2'h0,
  output logic [6:0] left_level_pct_out = 7'h00,
  output logic [6:0] right_level_pct_out = 7'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase = 2'h0;
  // Crossings every fourth cycle while zc_en_in is high, right channel louder
  always @(posedge clock_in) begin
    phase <= phase + 2'h1;
    zero_cross_out <= (zc_en_in && phase == 2'h0) ? 2'h3 : 2'h0;
    left_level_pct_out <= amp_in >> 1;
    right_level_pct_out <= amp_in;
  end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking testbench for the headphone gain and supply range control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  hpgc_pkg::hpgc_reg_req_t req = '0;
  logic [7:0] rdata;
  logic [1:0] zc;
  logic [6:0] lvl_l;
  logic [6:0] lvl_r;
  logic [6:0] amp = 7'h00;
  logic zc_en = 1'b0;
  hpgc_pkg::hpgc_chan_t ch [2];
  hpgc_pkg::hpgc_range_t rng;
  logic rail;
  logic [9:0] rate;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // 50 MHz clock
  always #10 clock_in = ~clock_in;
  hpgc_ctrl #(.DOWN_DELAY(8), .ZC_TIMEOUT(10), .STEP_TIME(4)) u_hpgc_ctrl (.clock_in(clock_in), .srst_in(srst_in),
    .reg_req_in(req), .reg_rdata_out(rdata), .zero_cross_in(zc), .left_level_pct_in(lvl_l),
    .right_level_pct_in(lvl_r), .chan_out(ch), .cp_range_out(rng), .cp_full_rail_out(rail), .cp_rate_khz_out(rate));
  hpgc_load u_hpgc_load (.clock_in(clock_in), .amp_in(amp), .zc_en_in(zc_en), .zero_cross_out(zc),
    .left_level_pct_out(lvl_l), .right_level_pct_out(lvl_r));
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    req = '{addr: a, wdata: d, wr: 1'b1};
    @(negedge clock_in);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock_in);
    req = '{addr: a, wdata: 8'h00, wr: 1'b0};
    @(negedge clock_in);
    chk("readback", rdata, e);
  endtask
  task automatic code_after(input int n, input logic [4:0] e);
    repeat (n) @(negedge clock_in);
    chk("left code", ch[0].level_code, e);
  endtask
  task automatic cp(input logic [6:0] a, input int n, input hpgc_pkg::hpgc_range_t r);
    amp = a;
    repeat (n) @(negedge clock_in);
    chk("range", rng, r);
    chk("rail", rail, r == hpgc_pkg::HPGC_RANGE_HIGH);
    chk("rate", rate, r == hpgc_pkg::HPGC_RANGE_LOW ? 10'h052 : r == hpgc_pkg::HPGC_RANGE_MID ? 10'h294 : 10'h1f4);
  endtask
  task automatic s_reset();
    rd(hpgc_pkg::RIGHT_VOL_ADDR, 8'h1a);
    rd(8'h41, 8'h00);
    chk("right code", ch[1].level_code, 5'h1a);
  endtask
  task automatic s_mix();
    for (int i = 0; i < 4; i++) begin
      wr(hpgc_pkg::MIX_GAIN_ADDR, 8'(i * 4 + 3 - i + (i % 2) * 16 + (1 - i % 2) * 32));
      repeat (2) @(negedge clock_in);
      chk("atten", {ch[1].mix_atten, ch[0].mix_atten}, {2'(i), 2'(3 - i)});
      chk("source", {ch[1].src_mixer, ch[0].src_mixer}, {1'(1 - i % 2), 1'(i % 2)});
    end
  endtask
  task automatic s_vol();
    logic [4:0] code [3] = '{5'h1f, 5'h1a, 5'h00};
    int gain [3] = '{6, 0, -134};
    wr(hpgc_pkg::ZC_CFG_ADDR, 8'h05);
    for (int i = 0; i < 3; i++) begin
      wr(hpgc_pkg::LEFT_VOL_ADDR, {3'h0, code[i]});
      code_after(2, code[i]);
      chk("gain", ch[0].gain_hdb, gain[i]);
    end
    wr(hpgc_pkg::LEFT_VOL_ADDR, 8'h9a);
    repeat (2) @(negedge clock_in);
    chk("mute", {ch[1].silenced, ch[0].silenced}, 2'h1);
    rd(hpgc_pkg::LEFT_VOL_ADDR, 8'h9a);
    wr(hpgc_pkg::LEFT_VOL_ADDR, 8'h1a);
    repeat (2) @(negedge clock_in);
    chk("mute", ch[0].silenced, 1'b0);
    wr(hpgc_pkg::RIGHT_VOL_ADDR, 8'h9f);
    repeat (2) @(negedge clock_in);
    chk("right mute and code", {ch[1].silenced, ch[1].level_code}, 6'h3f);
  endtask
  task automatic s_gate();
    wr(hpgc_pkg::ZC_CFG_ADDR, 8'h01);
    wr(hpgc_pkg::LEFT_VOL_ADDR, 8'h10);
    code_after(3, 5'h1a);
    zc_en = 1'b1;
    code_after(6, 5'h10);
    zc_en = 1'b0;
    wr(hpgc_pkg::LEFT_VOL_ADDR, 8'h05);
    code_after(10, 5'h10);
    code_after(1, 5'h05);
    wr(hpgc_pkg::ZC_CFG_ADDR, 8'h04);
    wr(hpgc_pkg::LEFT_VOL_ADDR, 8'h09);
    code_after(2, 5'h06);
    code_after(3, 5'h06);
    code_after(1, 5'h07);
    code_after(7, 5'h08);
    code_after(1, 5'h09);
  endtask
  task automatic s_pump();
    cp(7'd25, 4, hpgc_pkg::HPGC_RANGE_HIGH);
    cp(7'd20, 5, hpgc_pkg::HPGC_RANGE_HIGH);
    cp(7'd30, 1, hpgc_pkg::HPGC_RANGE_HIGH);
    cp(7'd20, 8, hpgc_pkg::HPGC_RANGE_HIGH);
    cp(7'd20, 6, hpgc_pkg::HPGC_RANGE_MID);
    cp(7'd5, 14, hpgc_pkg::HPGC_RANGE_LOW);
    cp(7'd10, 4, hpgc_pkg::HPGC_RANGE_MID);
  endtask
  // Hang guard
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    repeat (12) @(negedge clock_in);
    srst_in = 1'b0;
    s_reset();
    s_mix();
    s_vol();
    s_gate();
    s_pump();
    wrap_up();
  end
endmodule
`default_nettype wire
